/* File: dv/ssd_master_model.sv */
// Behavioural fieldbus master: sets up channels and supplies output data
`timescale 1ns/1ps
module ssd_master_model
	import ssd_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        srst_i,
	// Slave state seen and faults commanded by the bench
	input  wire logic [3:0]  state_i,
	input  wire logic        bad_mbx_i,
	input  wire logic        bad_pd_i,
	input  wire logic [15:0] out_val_i,
	// Setup results and output image
	output logic             mbx_ok_o,
	output logic             pd_ok_o,
	output logic             dc_used_o,
	output logic             dc_ok_o,
	output logic [15:0]      out_data_o
);
	// Setup trails the slave state by a cycle, as master software would
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			mbx_ok_o   <= 1'b0;
			pd_ok_o    <= 1'b0;
			dc_used_o  <= 1'b0;
			dc_ok_o    <= 1'b0;
			out_data_o <= 16'h0000;
		end else begin
			dc_used_o <= 1'b1;
			// Mailbox channels are only set up while the slave is in init
			if (state_i == REQ_INIT) begin
				mbx_ok_o <= !bad_mbx_i;
			end
			// Process-data channels and clocks set up in the config state
			if (state_i == REQ_PREOP) begin
				pd_ok_o <= !bad_pd_i;
				dc_ok_o <= !bad_pd_i;
			end
			// Output data always valid, so it precedes any run request
			out_data_o <= out_val_i;
		end
	end
endmodule

/* File: dv/tb_ssd_top.sv */
// Self-checking bench for the slave state sequencer and directory
`timescale 1ns/1ps
module tb_ssd_top;
	import ssd_pkg::*;
	// Identity values handed to the design, arbitrary
	localparam logic [31:0] VEN = 32'h0000_5A01;
	localparam logic [31:0] PRD = 32'h0000_5A02;
	localparam logic [31:0] REV = 32'h0000_5A03;
	localparam logic [31:0] SER = 32'h0000_5A04;
	localparam logic [15:0] SAFE = 16'h0000; // Outputs off
	// Bench drive
	logic        clk = 1'b0, srst = 1'b1, st_req = 1'b0, err_clr = 1'b0;
	logic [3:0]  st_code = 4'h0;
	logic        mbx_req = 1'b0, wdog_en = 1'b1, bad_mbx = 1'b1, bad_pd = 1'b1;
	logic [1:0]  svc = 2'h0, op = 2'h0;
	logic [15:0] idx = 16'h0000, in_data = 16'h0000, out_val = 16'h0000;
	logic [7:0]  sub = 8'h00;
	logic [31:0] wd = 32'h0000_0000, r;
	// Model and design outputs
	logic        mbx_ok, pd_ok, dc_used, dc_ok, ack, err, mbx_en, pd_en, acc, rej, rsp;
	logic [15:0] out_data, dpm_in, phys_out;
	logic [3:0]  state;
	logic [1:0]  err_code, dstat;
	logic [31:0] rdata;
	logic        acc_s, rej_s; // Mailbox verdict held past its pulse
	int          fail_count = 0, num_checks = 0, seed, s;

	// Free-running 100 MHz clock
	always #5 clk = ~clk;

	ssd_master_model i_master (.ref_clk_i(clk), .srst_i(srst), .state_i(state),
		.bad_mbx_i(bad_mbx), .bad_pd_i(bad_pd), .out_val_i(out_val), .mbx_ok_o(mbx_ok),
		.pd_ok_o(pd_ok), .dc_used_o(dc_used), .dc_ok_o(dc_ok), .out_data_o(out_data));

	ssd_top #(.SAFE_OUT(SAFE), .VENDOR(VEN), .PRODUCT(PRD), .REVISION(REV), .SERIAL(SER))
	i_dut (.ref_clk_i(clk), .srst_i(srst), .st_req_i(st_req), .st_code_i(st_code),
		.err_clr_i(err_clr), .mbx_cfg_ok_i(mbx_ok), .pd_cfg_ok_i(pd_ok), .dc_used_i(dc_used),
		.dc_cfg_ok_i(dc_ok), .mbx_req_i(mbx_req), .mbx_svc_i(svc), .dir_op_i(op),
		.dir_index_i(idx), .dir_sub_i(sub), .dir_wdata_i(wd), .in_data_i(in_data),
		.out_data_i(out_data), .wdog_en_i(wdog_en), .state_o(state), .st_ack_o(ack),
		.st_err_o(err), .err_code_o(err_code), .mbx_en_o(mbx_en), .pd_en_o(pd_en),
		.mbx_acc_o(acc), .mbx_rej_o(rej), .dir_rsp_o(rsp), .dir_status_o(dstat),
		.dir_rdata_o(rdata), .dpm_in_o(dpm_in), .phys_out_o(phys_out));

	// Expected identity value for a subindex
	function automatic logic [31:0] ident(input int k);
		case (k)
			1: ident = VEN;
			2: ident = PRD;
			3: ident = REV;
			default: ident = SER;
		endcase
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Wait n edges, then sample settled outputs
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// State request; answer sampled n-1 edges after the taking edge
	task automatic req(input logic [3:0] c, input int n);
		@(posedge clk);
		st_req <= 1'b1;
		st_code <= c;
		@(posedge clk);
		st_req <= 1'b0;
		settle(n - 1);
	endtask

	// Pulse the error clear and let setup inputs land
	task automatic clr();
		@(posedge clk);
		err_clr <= 1'b1;
		@(posedge clk);
		err_clr <= 1'b0;
		settle(1);
	endtask

	// One mailbox request; directory answers waited for under a bound
	task automatic mbx(input logic [1:0] v, input logic [1:0] o, input logic [15:0] i,
		input logic [7:0] b, input logic [31:0] w);
		int k;
		@(posedge clk);
		mbx_req <= 1'b1;
		{svc, op, idx, sub, wd} <= {v, o, i, b, w};
		@(posedge clk);
		mbx_req <= 1'b0;
		#1;
		{acc_s, rej_s} = {acc, rej};
		if (acc === 1'b1 && v == SVC_DIR) begin
			k = 0;
			while (rsp !== 1'b1 && k < 4) begin
				settle(1);
				k++;
			end
			if (k == 4) begin
				check("dir answer", 32'h0, 32'h1);
				report_and_stop();
			end
		end
	endtask

	// Directory access and its status
	task automatic dchk(input logic [1:0] o, input logic [15:0] i, input logic [7:0] b,
		input logic [31:0] w, input logic [1:0] st);
		mbx(SVC_DIR, o, i, b, w);
		check("dir acc", acc_s, 1'b1);
		check("dir status", dstat, st);
	endtask

	// Random process images; outputs follow master data or stay safe
	task automatic io_chk(input logic follow);
		repeat (4) begin
			@(posedge clk);
			in_data <= 16'($random(seed));
			out_val <= 16'($random(seed));
			settle(3);
			check("input image", dpm_in, in_data);
			check("phys out", phys_out, follow ? out_val : SAFE);
		end
	endtask

	// Main sequence
	initial begin
		seed = 32'hed30;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		settle(1);
		check("state", state, REQ_INIT);
		check("gates", {mbx_en, pd_en}, 2'b00);
		mbx(SVC_DIR, OP_READ, IDX_IDENTITY, SUB_VENDOR, 32'h0);
		check("rej in init", rej_s, 1'b1);
		req(REQ_PREOP, 1);
		check("bad mbx", {err, err_code, state}, {1'b1, ERR_MBX, REQ_INIT});
		bad_mbx <= 1'b0;
		clr();
		req(REQ_PREOP, 1);
		check("config", {ack, mbx_en, pd_en, state}, {3'b110, REQ_PREOP});
		$display("test init and config done");
		for (s = 1; s <= 4; s++) begin
			dchk(OP_READ, IDX_IDENTITY, s[7:0], 32'h0, DS_OK);
			check("identity", rdata, ident(s));
		end
		dchk(OP_WRITE, IDX_IDENTITY, SUB_PRODUCT, 32'h1, DS_RDONLY);
		dchk(OP_READ, IDX_IDENTITY, SUB_PRODUCT, 32'h0, DS_OK);
		check("ro kept", rdata, PRD);
		r = $random(seed);
		dchk(OP_WRITE, IDX_PARAM, SUB_FIRST, r, DS_OK);
		dchk(OP_READ, IDX_PARAM, SUB_FIRST, 32'h0, DS_OK);
		check("rw value", rdata, r);
		dchk(OP_READ, 16'h0FFF, SUB_ZERO, 32'h0, DS_NOTFOUND);
		dchk(OP_INFO, 16'h0, 8'h0, 32'h0, DS_OK);
		check("enum 0", rdata, {IDX_DEVTYPE, SUB_ZERO, INFO_PAD, 1'b0});
		dchk(OP_INFO, 16'h0, 8'h0, 32'h6, DS_OK);
		check("enum 6", rdata, {IDX_PARAM, SUB_FIRST, INFO_PAD, 1'b1});
		dchk(OP_INFO, 16'h0, 8'h0, 32'h7, DS_NOTFOUND);
		dchk(2'h3, IDX_PARAM, SUB_FIRST, 32'h0, DS_BADOP);
		$display("test directory done");
		req(REQ_OP, 1);
		check("cfg to run", {err_code, state}, {ERR_ILLEGAL, REQ_PREOP});
		req(REQ_BOOT, 1);
		check("cfg to boot", {err_code, state}, {ERR_ILLEGAL, REQ_PREOP});
		req(REQ_SAFEOP, 1);
		check("bad pd", {err, err_code, state}, {1'b1, ERR_PD, REQ_PREOP});
		bad_pd <= 1'b0;
		clr();
		in_data <= 16'($random(seed));
		req(REQ_SAFEOP, 2);
		check("inputs-only", {ack, pd_en, mbx_en, state}, {3'b111, REQ_SAFEOP});
		check("snapshot", dpm_in, in_data);
		io_chk(1'b0);
		wdog_en <= 1'b0;
		io_chk(1'b1);
		wdog_en <= 1'b1;
		$display("test inputs-only done");
		req(REQ_OP, 1);
		check("run", {ack, pd_en, state}, {2'b11, REQ_OP});
		io_chk(1'b1);
		$display("test run done");
		req(REQ_INIT, 1);
		check("back init", {mbx_en, state}, {1'b0, REQ_INIT});
		req(REQ_BOOT, 1);
		check("boot", {ack, pd_en, state}, {2'b10, REQ_BOOT});
		mbx(SVC_FILE, OP_READ, IDX_IDENTITY, SUB_VENDOR, 32'h0);
		check("file ok", acc_s, 1'b1);
		mbx(SVC_DIR, OP_READ, IDX_IDENTITY, SUB_VENDOR, 32'h0);
		check("dir refused", rej_s, 1'b1);
		mbx(SVC_OTHER, OP_READ, IDX_IDENTITY, SUB_VENDOR, 32'h0);
		check("other refused", rej_s, 1'b1);
		$display("test firmware update done");
		report_and_stop();
	end
endmodule

/* File: logic/ssd_dir.sv */
// Parameter directory: indexed entries with access attributes and enumeration
`timescale 1ns/1ps
module ssd_dir
	import ssd_pkg::*;
#(
	parameter logic [31:0] DEV_TYPE = 32'h0000_00A5, // Arbitrary value
	parameter logic [31:0] VENDOR   = 32'h0000_0A11, // Arbitrary value
	parameter logic [31:0] PRODUCT  = 32'h0000_0B22, // Arbitrary value
	parameter logic [31:0] REVISION = 32'h0000_0C33, // Arbitrary value
	parameter logic [31:0] SERIAL   = 32'h0000_0D44  // Arbitrary value
) (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic srst_i,
	// Sequencer side
	ssd_dir_if.dir    d
);

	logic [31:0]      val_q [DIR_ENTRIES]; // Entry values
	logic [31:0]      val_d [DIR_ENTRIES];
	logic             rsp_q, rsp_d;        // Answer strobe
	logic [1:0]       st_q, st_d;          // Answer code
	logic [31:0]      rd_q, rd_d;          // Answer data
	logic             hit;                 // Address matched an entry
	logic [POS_W-1:0] pos;                 // Matching entry
	logic [24:0]      key_scan;            // Key under comparison
	logic [24:0]      key_hit;             // Key of the matched entry
	logic [24:0]      key_enum;            // Key at the enumerate position

	// Entry key: main index, subindex, writable flag
	function automatic logic [24:0] ent_key(input int unsigned i);
		case (i)
			0:       ent_key = {IDX_DEVTYPE, SUB_ZERO, 1'b0};
			1:       ent_key = {IDX_RESTORE, SUB_FIRST, 1'b1};
			2:       ent_key = {IDX_IDENTITY, SUB_VENDOR, 1'b0};
			3:       ent_key = {IDX_IDENTITY, SUB_PRODUCT, 1'b0};
			4:       ent_key = {IDX_IDENTITY, SUB_REVISION, 1'b0};
			5:       ent_key = {IDX_IDENTITY, SUB_SERIAL, 1'b0};
			6:       ent_key = {IDX_PARAM, SUB_FIRST, 1'b1};
			default: ent_key = '0;
		endcase
	endfunction

	// Reset contents; read-only entries never change afterwards
	function automatic logic [31:0] ent_rst(input int unsigned i);
		case (i)
			0:       ent_rst = DEV_TYPE;
			2:       ent_rst = VENDOR;
			3:       ent_rst = PRODUCT;
			4:       ent_rst = REVISION;
			5:       ent_rst = SERIAL;
			default: ent_rst = RST_RW_VAL;
		endcase
	endfunction

	// Lookup and access decision
	always_comb begin
		val_d = val_q;
		rsp_d = d.req;
		st_d  = st_q;
		rd_d  = rd_q;
		hit      = 1'b0;
		pos      = '0;
		key_scan = '0;
		key_hit  = '0;
		// Function results cannot be sliced directly, so keys land in variables
		key_enum = ent_key(int'(d.wdata[POS_W-1:0]));
		// Index plus subindex addresses one entry
		for (int i = 0; i < DIR_ENTRIES; i++) begin
			key_scan = ent_key(i);
			if (key_scan[24:1] == {d.index, d.sub}) begin
				hit     = 1'b1;
				pos     = POS_W'(i);
				key_hit = key_scan;
			end
		end
		if (d.req) begin
			st_d = DS_OK;
			case (d.op)
				OP_READ: begin
					// Indices below the visible floor do not exist
					if (hit && d.index >= DIR_MIN_IDX) begin
						rd_d = val_q[pos];
					end else begin
						st_d = DS_NOTFOUND;
					end
				end
				OP_WRITE: begin
					if (!hit || d.index < DIR_MIN_IDX) begin
						st_d = DS_NOTFOUND;
					end else if (!key_hit[0]) begin
						st_d = DS_RDONLY;
					end else begin
						val_d[pos] = d.wdata;
					end
				end
				OP_INFO: begin
					// Enumeration by list position
					if (d.wdata < 32'(DIR_ENTRIES)) begin
						rd_d = {key_enum[24:1], INFO_PAD, key_enum[0]};
					end else begin
						st_d = DS_NOTFOUND;
					end
				end
				default: st_d = DS_BADOP;
			endcase
		end
	end

	// Register stage
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			for (int i = 0; i < DIR_ENTRIES; i++) begin
				val_q[i] <= ent_rst(i);
			end
			rsp_q <= 1'b0;
			st_q  <= DS_OK;
			rd_q  <= '0;
		end else begin
			val_q <= val_d;
			rsp_q <= rsp_d;
			st_q  <= st_d;
			rd_q  <= rd_d;
		end
	end

	assign d.rsp    = rsp_q;
	assign d.status = st_q;
	assign d.rdata  = rd_q;

endmodule

/* File: logic/ssd_dir_if.sv */
// Request and answer bundle between the sequencer and the parameter directory
`timescale 1ns/1ps
interface ssd_dir_if;
	logic        req;    // One-cycle directory request
	logic [1:0]  op;     // Read, write or enumerate
	logic [15:0] index;  // Main index
	logic [7:0]  sub;    // Subindex
	logic [31:0] wdata;  // Write value, or list position for enumerate
	logic        rsp;    // One-cycle answer
	logic [1:0]  status; // Answer code
	logic [31:0] rdata;  // Read value or entry description

	modport seq (output req, op, index, sub, wdata, input rsp, status, rdata);
	modport dir (input req, op, index, sub, wdata, output rsp, status, rdata);
endinterface

/* File: logic/ssd_pkg.sv */
// Shared constants and types for the slave state sequencer and parameter directory
package ssd_pkg;

	// Sequencer states, Gray coded along init, config, copy, inputs-only, run
	typedef enum logic [2:0] {
		ST_INIT   = 3'h0,
		ST_PREOP  = 3'h1,
		ST_COPY   = 3'h3,
		ST_SAFEOP = 3'h2,
		ST_OP     = 3'h6,
		ST_BOOT   = 3'h4
	} ssd_state_t;

	// State codes used by requests and by the reported state
	localparam logic [3:0] REQ_INIT   = 4'h1;
	localparam logic [3:0] REQ_PREOP  = 4'h2;
	localparam logic [3:0] REQ_BOOT   = 4'h3;
	localparam logic [3:0] REQ_SAFEOP = 4'h4;
	localparam logic [3:0] REQ_OP     = 4'h8;

	// Mailbox service classes
	localparam logic [1:0] SVC_DIR   = 2'h0;
	localparam logic [1:0] SVC_FILE  = 2'h1;
	localparam logic [1:0] SVC_OTHER = 2'h2;

	// Transition error codes
	localparam logic [1:0] ERR_NONE    = 2'h0;
	localparam logic [1:0] ERR_MBX     = 2'h1;
	localparam logic [1:0] ERR_PD      = 2'h2;
	localparam logic [1:0] ERR_ILLEGAL = 2'h3;

	// Directory operations and answers
	localparam logic [1:0] OP_READ     = 2'h0;
	localparam logic [1:0] OP_WRITE    = 2'h1;
	localparam logic [1:0] OP_INFO     = 2'h2;
	localparam logic [1:0] DS_OK       = 2'h0;
	localparam logic [1:0] DS_NOTFOUND = 2'h1;
	localparam logic [1:0] DS_RDONLY   = 2'h2;
	localparam logic [1:0] DS_BADOP    = 2'h3;

	// Directory layout
	localparam logic [15:0] DIR_MIN_IDX  = 16'h1000;
	localparam logic [15:0] IDX_DEVTYPE  = 16'h1000;
	localparam logic [15:0] IDX_RESTORE  = 16'h1011;
	localparam logic [15:0] IDX_IDENTITY = 16'h1018;
	localparam logic [15:0] IDX_PARAM    = 16'h8000;
	localparam logic [7:0]  SUB_ZERO     = 8'h00;
	localparam logic [7:0]  SUB_VENDOR   = 8'h01;
	localparam logic [7:0]  SUB_PRODUCT  = 8'h02;
	localparam logic [7:0]  SUB_REVISION = 8'h03;
	localparam logic [7:0]  SUB_SERIAL   = 8'h04;
	localparam logic [7:0]  SUB_FIRST    = 8'h01;
	localparam logic [31:0] RST_RW_VAL   = 32'h0000_0000;
	localparam logic [6:0]  INFO_PAD     = 7'h00;
	localparam int          DIR_ENTRIES  = 7;
	localparam int          POS_W        = 3;

endpackage

/* File: logic/ssd_top.sv */
// Slave state sequencer with traffic gating, output safety and input snapshot
// Summary of operation
// - Power-on enters init; no traffic allowed
// - Init to config checks mailbox setup
// - Config state: mailbox yes, process data no
// - Config to inputs-only checks channels, clocks
// - Inputs snapshotted before inputs-only acknowledge
// - Inputs-only: traffic on, outputs held safe
// - Watchdog forces safe outputs in inputs-only unless disabled
// - Run state drives outputs from master
// - Firmware-update entered only from init
// - Firmware-update accepts only file-transfer mailbox
// - Entries addressed by main index and subindex
// - Write attempts honour read-only attribute
// - Identity entries are read-only
// - Visible indices start at the floor
// - Directory reachable from config state onward
// - Directory enumerable through mailbox information service
`timescale 1ns/1ps
module ssd_top
	import ssd_pkg::*;
#(
	parameter int          IN_W     = 16,           // Input image width
	parameter int          OUT_W    = 16,           // Output image width
	parameter logic [15:0] SAFE_OUT = 16'h0000,     // Safe output value (off)
	parameter logic [31:0] DEV_TYPE = 32'h0000_00A5, // Arbitrary value
	parameter logic [31:0] VENDOR   = 32'h0000_0A11, // Arbitrary value
	parameter logic [31:0] PRODUCT  = 32'h0000_0B22, // Arbitrary value
	parameter logic [31:0] REVISION = 32'h0000_0C33, // Arbitrary value
	parameter logic [31:0] SERIAL   = 32'h0000_0D44  // Arbitrary value
) (
	// Clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              srst_i,
	// State requests from the master
	input  wire logic              st_req_i,
	input  wire logic [3:0]        st_code_i,
	input  wire logic              err_clr_i,
	// Configuration checks
	input  wire logic              mbx_cfg_ok_i,
	input  wire logic              pd_cfg_ok_i,
	input  wire logic              dc_used_i,
	input  wire logic              dc_cfg_ok_i,
	// Mailbox requests
	input  wire logic              mbx_req_i,
	input  wire logic [1:0]        mbx_svc_i,
	input  wire logic [1:0]        dir_op_i,
	input  wire logic [15:0]       dir_index_i,
	input  wire logic [7:0]        dir_sub_i,
	input  wire logic [31:0]       dir_wdata_i,
	// Process data and physical I/O
	input  wire logic [IN_W-1:0]   in_data_i,
	input  wire logic [OUT_W-1:0]  out_data_i,
	input  wire logic              wdog_en_i,
	// State status
	output logic [3:0]             state_o,
	output logic                   st_ack_o,
	output logic                   st_err_o,
	output logic [1:0]             err_code_o,
	// Traffic gating
	output logic                   mbx_en_o,
	output logic                   pd_en_o,
	output logic                   mbx_acc_o,
	output logic                   mbx_rej_o,
	// Directory answers
	output logic                   dir_rsp_o,
	output logic [1:0]             dir_status_o,
	output logic [31:0]            dir_rdata_o,
	// Process images
	output logic [IN_W-1:0]        dpm_in_o,
	output logic [OUT_W-1:0]       phys_out_o
);

	ssd_state_t       state_q, state_d;     // Sequencer state
	logic [3:0]       code_q, code_d;       // Reported state code
	logic             ack_q, ack_d;         // Transition done pulse
	logic             err_q, err_d;         // Sticky transition error
	logic [1:0]       ecode_q, ecode_d;     // Last error cause
	logic             mbx_en_q, mbx_en_d;   // Mailbox allowed
	logic             pd_en_q, pd_en_d;     // Process data allowed
	logic             acc_q, acc_d;         // Mailbox accepted pulse
	logic             rej_q, rej_d;         // Mailbox refused pulse
	logic             drsp_q, drsp_d;       // Directory answer pulse
	logic [1:0]       dst_q, dst_d;         // Directory answer code
	logic [31:0]      drd_q, drd_d;         // Directory answer data
	logic [IN_W-1:0]  dpm_q, dpm_d;         // Input image in shared memory
	logic [OUT_W-1:0] phys_q, phys_d;       // Physical outputs
	logic             go;                   // Requested move allowed
	logic [1:0]       why;                  // Failure cause if not
	ssd_state_t       tgt;                  // Requested target
	logic             mbx_ok;               // Current mailbox request allowed
	logic             dir_open;             // Directory reachable now

	ssd_dir_if dif ();

	// Directory instance
	ssd_dir #(
		.DEV_TYPE (DEV_TYPE),
		.VENDOR   (VENDOR),
		.PRODUCT  (PRODUCT),
		.REVISION (REVISION),
		.SERIAL   (SERIAL)
	) u_dir (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.d         (dif.dir)
	);

	// Transition decision; checks run only on moves that need them
	always_comb begin
		go  = 1'b0;
		why = ERR_ILLEGAL;
		tgt = state_q;
		case (st_code_i)
			REQ_INIT: begin
				go  = 1'b1;
				tgt = ST_INIT;
			end
			REQ_PREOP: begin
				if (state_q == ST_INIT) begin
					go  = mbx_cfg_ok_i;
					why = ERR_MBX;
					tgt = ST_PREOP;
				end else if (state_q != ST_BOOT) begin
					go  = 1'b1;
					tgt = ST_PREOP;
				end
			end
			REQ_BOOT: begin
				// Only init leads into firmware update
				if (state_q == ST_INIT) begin
					go  = mbx_cfg_ok_i;
					why = ERR_MBX;
					tgt = ST_BOOT;
				end else if (state_q == ST_BOOT) begin
					go  = 1'b1;
				end
			end
			REQ_SAFEOP: begin
				if (state_q == ST_PREOP) begin
					go  = pd_cfg_ok_i && (!dc_used_i || dc_cfg_ok_i);
					why = ERR_PD;
					tgt = ST_COPY;
				end else if (state_q == ST_SAFEOP || state_q == ST_OP) begin
					go  = 1'b1;
					tgt = ST_SAFEOP;
				end
			end
			REQ_OP: begin
				// Output data validity is the master's duty before this move
				if (state_q == ST_SAFEOP || state_q == ST_OP) begin
					go  = 1'b1;
					tgt = ST_OP;
				end
			end
			default: go = 1'b0;
		endcase
	end

	// Sequencer next state
	always_comb begin
		state_d = state_q;
		ack_d   = 1'b0;
		ecode_d = ecode_q;
		err_d   = err_q && !err_clr_i;
		case (state_q)
			ST_COPY: begin
				// Snapshot taken this cycle, acknowledge with it
				state_d = ST_SAFEOP;
				ack_d   = 1'b1;
			end
			default: begin
				if (st_req_i) begin
					if (go) begin
						state_d = tgt;
						ack_d   = (tgt != ST_COPY);
					end else begin
						// Stay put; a new failure beats a clear
						err_d   = 1'b1;
						ecode_d = why;
					end
				end
			end
		endcase
		case (state_d)
			ST_PREOP, ST_COPY: code_d = REQ_PREOP;
			ST_SAFEOP:         code_d = REQ_SAFEOP;
			ST_OP:             code_d = REQ_OP;
			ST_BOOT:           code_d = REQ_BOOT;
			default:           code_d = REQ_INIT;
		endcase
	end

	// Traffic gating by state
	always_comb begin
		dir_open = (state_q == ST_PREOP || state_q == ST_SAFEOP ||
			state_q == ST_OP);
		case (state_q)
			ST_INIT:  mbx_ok = 1'b0;
			ST_BOOT:  mbx_ok = (mbx_svc_i == SVC_FILE);
			ST_COPY:  mbx_ok = 1'b1;
			default:  mbx_ok = 1'b1;
		endcase
		acc_d    = mbx_req_i && mbx_ok;
		rej_d    = mbx_req_i && !mbx_ok;
		mbx_en_d = (state_d != ST_INIT);
		pd_en_d  = (state_d == ST_SAFEOP || state_d == ST_OP);
		drsp_d   = dif.rsp;
		dst_d    = dif.status;
		drd_d    = dif.rdata;
	end

	// Directory requests ride on accepted mailbox requests
	assign dif.req   = mbx_req_i && (mbx_svc_i == SVC_DIR) && dir_open;
	assign dif.op    = dir_op_i;
	assign dif.index = dir_index_i;
	assign dif.sub   = dir_sub_i;
	assign dif.wdata = dir_wdata_i;

	// Process images: inputs refresh each cycle once inputs are live
	always_comb begin
		dpm_d = dpm_q;
		if (state_q == ST_COPY || state_q == ST_SAFEOP || state_q == ST_OP) begin
			dpm_d = in_data_i;
		end
		// Watchdog on keeps outputs safe until full run
		if (state_q == ST_OP || (state_q == ST_SAFEOP && !wdog_en_i)) begin
			phys_d = out_data_i;
		end else begin
			phys_d = SAFE_OUT[OUT_W-1:0];
		end
	end

	// Register everything
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			state_q  <= ST_INIT;
			code_q   <= REQ_INIT;
			ack_q    <= 1'b0;
			err_q    <= 1'b0;
			ecode_q  <= ERR_NONE;
			mbx_en_q <= 1'b0;
			pd_en_q  <= 1'b0;
			acc_q    <= 1'b0;
			rej_q    <= 1'b0;
			drsp_q   <= 1'b0;
			dst_q    <= DS_OK;
			drd_q    <= '0;
			dpm_q    <= '0;
			phys_q   <= SAFE_OUT[OUT_W-1:0];
		end else begin
			state_q  <= state_d;
			code_q   <= code_d;
			ack_q    <= ack_d;
			err_q    <= err_d;
			ecode_q  <= ecode_d;
			mbx_en_q <= mbx_en_d;
			pd_en_q  <= pd_en_d;
			acc_q    <= acc_d;
			rej_q    <= rej_d;
			drsp_q   <= drsp_d;
			dst_q    <= dst_d;
			drd_q    <= drd_d;
			dpm_q    <= dpm_d;
			phys_q   <= phys_d;
		end
	end

	assign state_o      = code_q;
	assign st_ack_o     = ack_q;
	assign st_err_o     = err_q;
	assign err_code_o   = ecode_q;
	assign mbx_en_o     = mbx_en_q;
	assign pd_en_o      = pd_en_q;
	assign mbx_acc_o    = acc_q;
	assign mbx_rej_o    = rej_q;
	assign dir_rsp_o    = drsp_q;
	assign dir_status_o = dst_q;
	assign dir_rdata_o  = drd_q;
	assign dpm_in_o     = dpm_q;
	assign phys_out_o   = phys_q;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	// Init carries no traffic at all
	chk_init_no_traffic: assert property (
		(state_q == ST_INIT) |-> (!pd_en_q && !mbx_en_q)
	) else $error("traffic enabled in init");

	// Entry to config only with a good mailbox setup
	chk_preop_entry_check: assert property (
		($past(state_q) == ST_INIT && state_q == ST_PREOP) |-> $past(mbx_cfg_ok_i)
	) else $error("config entered without mailbox check");

	// Config serves mailbox but no process data
	chk_preop_no_pd: assert property (
		(state_q == ST_PREOP) |-> (mbx_en_q && !pd_en_q)
	) else $error("process data in config state");

	// Copy step only after channel and clock checks
	chk_copy_after_check: assert property (
		(state_q == ST_COPY) |-> ($past(pd_cfg_ok_i) && (!$past(dc_used_i) || $past(dc_cfg_ok_i)))
	) else $error("inputs-only move without checks");

	// Acknowledge carries the snapshot taken in the copy cycle
	chk_snapshot_ack: assert property (
		(state_q == ST_SAFEOP && $past(state_q) == ST_COPY) |->
			(ack_q && dpm_in_o == $past(in_data_i))
	) else $error("inputs-only acknowledged without snapshot");

	// Watchdog keeps outputs safe in inputs-only
	chk_safe_outputs: assert property (
		(state_q == ST_SAFEOP && wdog_en_i) |=> (phys_out_o == SAFE_OUT[OUT_W-1:0])
	) else $error("outputs not safe in inputs-only state");

	// Run state copies master outputs
	chk_run_outputs: assert property (
		(state_q == ST_OP) |=> (phys_out_o == $past(out_data_i))
	) else $error("run outputs not from master data");

	// Firmware update reached only from init
	chk_boot_entry: assert property (
		(state_q == ST_BOOT && $past(state_q) != ST_BOOT) |-> ($past(state_q) == ST_INIT)
	) else $error("firmware update entered from wrong state");

	// Firmware update refuses all but file transfer
	chk_boot_filter: assert property (
		(state_q == ST_BOOT && mbx_req_i && mbx_svc_i != SVC_FILE) |=> (rej_q && !acc_q)
	) else $error("non-file service accepted in firmware update");

	// Directory closed in init
	chk_dir_closed: assert property (
		(state_q == ST_INIT && mbx_req_i && mbx_svc_i == SVC_DIR) |=> ##1 !drsp_q
	) else $error("directory answered in init");

	// Failed check holds state and flags the cause
	chk_fail_holds: assert property (
		(st_req_i && state_q == ST_INIT && st_code_i == REQ_PREOP && !mbx_cfg_ok_i)
			|=> (state_q == ST_INIT && err_q && ecode_q == ERR_MBX && !ack_q)
	) else $error("failed check changed state or lost error");

endmodule
